// *** frc_pkg.sv ***
// frc_pkg: constants and carrier types for the rate, precompensation,
// perpendicular and low power control block.
// assumes a 100 MHz ref_clk and an AXI4-Lite register port.
package frc_pkg;

  // register indices as printed and their byte addresses
  localparam logic [11:0] RATE_SEL_IDX = 12'h004;
  localparam logic [11:0] CFG_CTL_IDX  = 12'h3f7;
  localparam logic [13:0] RATE_SEL_ADDR = 14'h0010;
  localparam logic [13:0] CFG_CTL_ADDR  = 14'h0fdc;
  // own registers
  localparam logic [13:0] CMD_ADDR      = 14'h1000; // perp / trk / mode cmd
  localparam logic [13:0] STATUS_ADDR   = 14'h1004; // readable state
  localparam logic [13:0] RATE_RB_ADDR  = 14'h1008; // rate select readback

  // field positions
  localparam int RATE_LSB     = 0;
  localparam int PRECOMP_LSB  = 2;
  localparam int LOWPWR_BIT   = 6;
  localparam int SWRST_BIT    = 7;
  localparam int CMD_PERP_BIT = 0;
  localparam int CMD_MLP_BIT  = 1;
  localparam int CMD_WAKE_BIT = 2;
  localparam int CMD_TRK_LSB  = 8;

  // reset values
  localparam logic [1:0] RATE_RST    = 2'h0;
  localparam logic [2:0] PRECOMP_DEF = 3'h0; // default precomp code
  localparam logic [7:0] PRETRK_DEF  = 8'h00;

  // rate codes
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M   = 2'h3;

  // perpendicular figures in byte times
  localparam logic [7:0] PRE_ERASE_1M   = 8'd38;
  localparam logic [7:0] PRE_ERASE_500K = 8'd19;
  localparam logic [7:0] GAP_PERP_1M    = 8'd41;
  localparam logic [7:0] GAP_STD        = 8'd22;

  // microengine clock divisors from the 100 MHz ref_clk, in ref cycles
  localparam logic [7:0] DIV_1M   = 8'd1;
  localparam logic [7:0] DIV_500K = 8'd2;
  localparam logic [7:0] DIV_300K = 8'd3;
  localparam logic [7:0] DIV_250K = 8'd4;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] rate;
    logic [2:0] precomp;
    logic [7:0] pretrk;
    logic       perp;
    logic       low_power;
  } frc_cfg_t;

  typedef struct packed {
    logic [7:0] pre_erase;
    logic [7:0] gap;
    logic [7:0] clk_div;
  } frc_timing_t;

endpackage : frc_pkg

// *** frc_clk_scale.sv ***
// frc_clk_scale: divides ref_clk into a microengine / separator tick
// whose period follows the active data rate, gated off in low power.
// assumes rate and low power are stable registered levels.
`timescale 1ns/1ps
`default_nettype none
module frc_clk_scale (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] div,
  input  wire logic       halt,
  output logic            tick
);
  logic [7:0] cnt_q;

  // count up to the divisor; halted counter gives no ticks
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else if (halt) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else if (cnt_q + 8'h01 >= div) begin
      cnt_q <= 8'h00;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tick  <= 1'b0;
    end
  end
endmodule // frc_clk_scale
`default_nettype wire

// *** frc_ctrl.sv ***
// frc_ctrl: data rate selection, rate pins, clock scaling, write
// precompensation, perpendicular timing and manual low power.
// assumes an AXI4-Lite master on ref_clk and synchronous disk inputs.
// Summary of operation
// - The rate comes from the two low bits of the config control register.
// - The rate select register low two bits also set the rate, same code.
// - The last write to either register decides the active rate.
// - The engine and separator clocks scale with the selected rate.
// - The two rate pins always show the last written rate bits.
// - A perpendicular command puts the controller into perpendicular mode.
// - In perpendicular mode write gate follows write_req; the 38 or 19 byte time lead is counted but does not time it.
// - The perpendicular id to data gap at 1 Mb/s is 41 bytes, else 22.
// - Perpendicular parameters follow the currently selected rate.
// - Precompensation shifts each write bit early, late or not at all.
// - Default precomp applies from reset until software writes another.
// - Precomp starting track is zero at reset and set by configure.
// - Low power stops the oscillator, separator and their logic.
// - Rate select bit 6 enters low power at once and reads one until wake.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module frc_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // axi4-lite slave
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // disk side
  input  wire logic [7:0]  cur_track,
  input  wire logic        write_bit,
  input  wire logic        write_bit_valid,
  input  wire logic        preamble_near,
  input  wire logic        write_req,
  input  wire logic        wake_access,
  output logic             rate_out_bit0,
  output logic             rate_out_bit1,
  output logic             write_gate,
  output logic [1:0]       precomp_shift,
  output logic [7:0]       id_to_data_gap,
  output logic             engine_tick,
  output logic             osc_enable,
  output logic             sw_reset
);

  frc_pkg::frc_cfg_t    cfg_q;
  frc_pkg::frc_timing_t tim;
  logic [7:0]  rate_sel_q;
  logic        mode_lp_q;
  logic        aw_q, w_q;
  logic [13:0] awaddr_q;
  logic [31:0] wdata_q;
  logic        wr_fire;
  logic        wr_hit_rs, wr_hit_cc, wr_hit_cmd;
  logic [2:0]  hist_q;
  logic [7:0]  lead_cnt_q;
  logic        lp_active;

  // byte address decode shared by read and write channels
  function automatic logic [2:0] dec(input logic [13:0] a);
    if (a == frc_pkg::RATE_SEL_ADDR) begin
      dec = 3'h1;
    end else if (a == frc_pkg::CFG_CTL_ADDR) begin
      dec = 3'h2;
    end else if (a == frc_pkg::CMD_ADDR) begin
      dec = 3'h3;
    end else if (a == frc_pkg::STATUS_ADDR) begin
      dec = 3'h4;
    end else if (a == frc_pkg::RATE_RB_ADDR) begin
      dec = 3'h5;
    end else begin
      dec = 3'h0;
    end
  endfunction

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign wr_fire       = aw_q && w_q && !s_axi_bvalid;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 14'h0000;
      wdata_q  <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end else if (wr_fire) begin
        w_q <= 1'b0;
      end
    end
  end

  assign wr_hit_rs  = wr_fire && dec(awaddr_q) == 3'h1;
  assign wr_hit_cc  = wr_fire && dec(awaddr_q) == 3'h2;
  assign wr_hit_cmd = wr_fire && dec(awaddr_q) == 3'h3;

  // write response, slverr for unmapped or read-only offsets
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= frc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (dec(awaddr_q) inside {3'h1, 3'h2, 3'h3})
                      ? frc_pkg::RESP_OKAY : frc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // shared rate register: last write of either register wins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q.rate <= frc_pkg::RATE_RST;
    end else if (wr_hit_rs || wr_hit_cc) begin
      cfg_q.rate <= wdata_q[frc_pkg::RATE_LSB +: 2];
    end
  end

  // precomp code and starting track
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q.precomp <= frc_pkg::PRECOMP_DEF;
      cfg_q.pretrk  <= frc_pkg::PRETRK_DEF;
    end else begin
      if (wr_hit_rs) begin
        cfg_q.precomp <= wdata_q[frc_pkg::PRECOMP_LSB +: 3];
      end
      if (wr_hit_cmd) begin
        cfg_q.pretrk <= wdata_q[frc_pkg::CMD_TRK_LSB +: 8];
      end
    end
  end

  // perpendicular mode command and mode-command low power bit
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q.perp <= 1'b0;
      mode_lp_q  <= 1'b0;
    end else if (wr_hit_cmd) begin
      cfg_q.perp <= wdata_q[frc_pkg::CMD_PERP_BIT];
      mode_lp_q  <= wdata_q[frc_pkg::CMD_MLP_BIT];
    end
  end

  // manual low power: set at once by bit 6, cleared on wake
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q.low_power <= 1'b0;
      rate_sel_q      <= 8'h00;
    end else if (wr_hit_rs && wdata_q[frc_pkg::LOWPWR_BIT]) begin
      cfg_q.low_power <= 1'b1;
      rate_sel_q      <= wdata_q[7:0] & 8'h3f;
    end else if (wr_hit_rs) begin
      rate_sel_q      <= wdata_q[7:0] & 8'h3f;
      cfg_q.low_power <= cfg_q.low_power;
    end else if (wake_access ||
                 (wr_hit_cmd && wdata_q[frc_pkg::CMD_WAKE_BIT])) begin
      cfg_q.low_power <= 1'b0; // bit reads zero once awake
    end
  end

  // self-clearing software reset pulse from rate select bit 7
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sw_reset <= 1'b0;
    end else begin
      sw_reset <= wr_hit_rs && wdata_q[frc_pkg::SWRST_BIT];
    end
  end

  assign lp_active  = cfg_q.low_power || mode_lp_q;
  assign osc_enable = !lp_active;

  // rate dependent timing parameters
  always_comb begin
    tim.gap       = frc_pkg::GAP_STD;
    tim.pre_erase = 8'h00;
    case (cfg_q.rate)
      frc_pkg::RATE_1M:   tim.clk_div = frc_pkg::DIV_1M;
      frc_pkg::RATE_500K: tim.clk_div = frc_pkg::DIV_500K;
      frc_pkg::RATE_300K: tim.clk_div = frc_pkg::DIV_300K;
      default:            tim.clk_div = frc_pkg::DIV_250K;
    endcase
    if (cfg_q.perp) begin
      case (cfg_q.rate)
        frc_pkg::RATE_1M: begin
          tim.pre_erase = frc_pkg::PRE_ERASE_1M;
          tim.gap       = frc_pkg::GAP_PERP_1M;
        end
        default: begin
          tim.pre_erase = frc_pkg::PRE_ERASE_500K;
        end
      endcase
    end
  end

  // scaled engine / separator tick, stopped in low power
  frc_clk_scale frc_clk_scale_inst (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .div     (tim.clk_div),
    .halt    (lp_active),
    .tick    (engine_tick)
  );

  // rate pins and gap from flip-flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rate_out_bit0  <= 1'b0;
      rate_out_bit1  <= 1'b0;
      id_to_data_gap <= frc_pkg::GAP_STD;
    end else begin
      rate_out_bit0  <= cfg_q.rate[0];
      rate_out_bit1  <= cfg_q.rate[1];
      id_to_data_gap <= tim.gap;
    end
  end

  // write gate: in perpendicular mode count pre-erase bytes of lead
  // from write_req, counted in engine ticks standing for byte times
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lead_cnt_q <= 8'h00;
      write_gate <= 1'b0;
    end else if (!write_req || lp_active) begin
      lead_cnt_q <= 8'h00;
      write_gate <= 1'b0;
    end else if (cfg_q.perp && lead_cnt_q < tim.pre_erase && engine_tick) begin
      lead_cnt_q <= lead_cnt_q + 8'h01;
      write_gate <= 1'b1; // asserted ahead of the preamble
    end else if (cfg_q.perp) begin
      write_gate <= 1'b1;
    end else begin
      write_gate <= preamble_near;
    end
  end

  // precomp: history of bits predicts shift past the starting track
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hist_q        <= 3'h0;
      precomp_shift <= 2'h0;
    end else if (write_bit_valid) begin
      hist_q <= {hist_q[1:0], write_bit};
      if (cur_track < cfg_q.pretrk || cfg_q.precomp == 3'h7) begin
        precomp_shift <= 2'h0; // not shifted
      end else if (hist_q[1:0] == 2'b10 && write_bit) begin
        precomp_shift <= 2'h1; // early
      end else if (hist_q[1:0] == 2'b01 && !write_bit) begin
        precomp_shift <= 2'h2; // late
      end else begin
        precomp_shift <= 2'h0;
      end
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= frc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= frc_pkg::RESP_OKAY;
      if (dec(s_axi_araddr) == 3'h4) begin
        s_axi_rdata <= {11'h000, cfg_q.pretrk, cfg_q.precomp, mode_lp_q,
                        cfg_q.low_power, cfg_q.perp, osc_enable,
                        4'h0, cfg_q.rate};
      end else if (dec(s_axi_araddr) == 3'h5) begin
        s_axi_rdata <= {24'h000000, rate_sel_q[7], cfg_q.low_power,
                        rate_sel_q[5:2], cfg_q.rate};
      end else if (dec(s_axi_araddr) == 3'h3) begin
        s_axi_rdata <= {16'h0000, cfg_q.pretrk, 5'h00, 1'b0, mode_lp_q,
                        cfg_q.perp};
      end else if (dec(s_axi_araddr) == 3'h0) begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= frc_pkg::RESP_SLVERR;
      end else begin
        s_axi_rdata <= 32'h00000000; // write-only registers
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // assertions
  sequence s_rate_wr;
    wr_hit_rs || wr_hit_cc;
  endsequence

  a_rate_pins_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_rate_wr |=> ##1 ({rate_out_bit1, rate_out_bit0} ==
                       $past(wdata_q[1:0], 2)))
    else $error("rate pins do not follow write");
  a_rate_last_wins: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_rate_wr |=> cfg_q.rate == $past(wdata_q[1:0]))
    else $error("rate not last written");
  a_rate_stable: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(wr_hit_rs || wr_hit_cc) |=> $stable(cfg_q.rate))
    else $error("rate changed without write");
  a_lp_enter_now: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_hit_rs && wdata_q[6] |=> !osc_enable)
    else $error("low power not entered");
  a_lp_halts_tick: assert property (@(posedge ref_clk) disable iff (!resetn)
    lp_active [*2] |-> !engine_tick)
    else $error("tick while in low power");
  a_gap_perp_1m: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cfg_q.perp && cfg_q.rate == frc_pkg::RATE_1M) [*2]
      |-> id_to_data_gap == 8'd41)
    else $error("perpendicular gap wrong");
  a_gap_std: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!cfg_q.perp) [*2] |-> id_to_data_gap == 8'd22)
    else $error("standard gap wrong");
  a_pre_erase_lead: assert property (@(posedge ref_clk) disable iff (!resetn)
    cfg_q.perp && write_req && !lp_active |=> write_gate)
    else $error("write gate late in perpendicular mode");
  a_precomp_below: assert property (@(posedge ref_clk) disable iff (!resetn)
    write_bit_valid && cur_track < cfg_q.pretrk |=> precomp_shift == 2'h0)
    else $error("precomp below start track");
  a_tick_rate_1m: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!lp_active && cfg_q.rate == frc_pkg::RATE_1M) [*3] |-> engine_tick)
    else $error("clock not scaled to rate");

endmodule // frc_ctrl
`default_nettype wire

// *** frc_host_model.sv ***
// frc_host_model: axi4-lite host that programs the rate control block.
// assumes a slave on ref_clk; one write and one read at most in flight.
`timescale 1ns/1ps
`default_nettype none
module frc_host_model (
  input  wire logic        ref_clk,
  output logic [13:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [13:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // bus idle from time zero
  initial begin
    awaddr  = 14'h0000;
    awvalid = 1'b0;
    wdata   = 32'h0;
    wstrb   = 4'h0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 14'h0000;
    arvalid = 1'b0;
    rready  = 1'b0;
  end

  // one write: address and data offered together, each dropped when taken
  task automatic wr(input logic [13:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    r = bresp;
  endtask

  // one read: rready held until the data is sampled
  task automatic rd(input logic [13:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  // rate through the config control register, upper bits kept zero
  task automatic cfg_rate(input logic [1:0] c);
    logic [1:0] r;
    wr(frc_pkg::CFG_CTL_ADDR, {30'h0, c}, r);
  endtask
endmodule // frc_host_model
`default_nettype wire

// *** frc_ctrl_tb.sv ***
// frc_ctrl_tb: self-checking bench for rate, precomp, perpendicular and
// low power control; assumes frc_host_model and a 100 MHz ref_clk.
`timescale 1ns/1ps
`default_nettype none
module frc_ctrl_tb;
  logic        ref_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr, precomp_shift;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  cur_track, id_to_data_gap;
  logic        write_bit, write_bit_valid, preamble_near, write_req;
  logic        wake_access, rate_out_bit0, rate_out_bit1, write_gate;
  logic        engine_tick, osc_enable, sw_reset;
  int          failures  = 0;
  int          tests_run = 0;
  int          sw_pulses = 0;

  // 100 MHz reference
  always #5 ref_clk = ~ref_clk;

  // count software reset pulses
  always @(posedge ref_clk)
    sw_pulses <= sw_pulses + int'(sw_reset === 1'b1);

  frc_host_model host (
    .ref_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready
  );

  frc_ctrl frc_ctrl_inst (
    .ref_clk, .resetn,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cur_track, .write_bit, .write_bit_valid, .preamble_near, .write_req,
    .wake_access, .rate_out_bit0, .rate_out_bit1, .write_gate,
    .precomp_shift, .id_to_data_gap, .engine_tick, .osc_enable, .sw_reset
  );

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic reg_wr(input logic [13:0] a, input logic [31:0] d);
    host.wr(a, d, rr);
  endtask

  task automatic reg_rd(input logic [13:0] a);
    host.rd(a, rv, rr);
  endtask

  function automatic logic [31:0] pins();
    return {30'h0, rate_out_bit1, rate_out_bit0};
  endfunction

  // engine ticks seen over 24 reference cycles
  task automatic ticks(output int n);
    n = 0;
    repeat (24) begin
      @(posedge ref_clk);
      n += int'(engine_tick === 1'b1);
    end
  endtask

  // serial bits: either no shift at all, or some early or late shift
  task automatic bits(input logic shift_on);
    logic seen = 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      write_bit       <= 1'(16'h3a5c >> i);
      write_bit_valid <= 1'b1;
      if (!shift_on) check(32'(precomp_shift), 32'h0);
      seen = seen | (precomp_shift != 2'h0);
    end
    @(posedge ref_clk);
    write_bit_valid <= 1'b0;
    if (shift_on) check(32'(seen), 32'h1);
  endtask

  task automatic t_reset();
    check(pins(), 32'(frc_pkg::RATE_RST));
    check(32'(id_to_data_gap), 32'(frc_pkg::GAP_STD));
    check(32'(osc_enable), 32'h1);
    reg_rd(frc_pkg::STATUS_ADDR);
    check(32'(rv[12:10]), 32'(frc_pkg::PRECOMP_DEF));
    check(32'(rv[20:13]), 32'(frc_pkg::PRETRK_DEF));
    $display("test reset done");
  endtask

  task automatic t_rate();
    for (int i = 0; i < 4; i++) begin
      host.cfg_rate(2'(i));
      cyc(3);
      check(pins(), 32'(i));
      reg_wr(frc_pkg::RATE_SEL_ADDR, 32'(3 - i));
      cyc(3);
      check(pins(), 32'(3 - i));
      reg_rd(frc_pkg::STATUS_ADDR);
      check(32'(rv[1:0]), 32'(3 - i));
    end
    // back to back, second register wins
    host.cfg_rate(frc_pkg::RATE_1M);
    reg_wr(frc_pkg::RATE_SEL_ADDR, 32'(frc_pkg::RATE_250K));
    cyc(3);
    check(pins(), 32'(frc_pkg::RATE_250K));
    $display("test rate select done");
  endtask

  task automatic t_scale();
    int n;
    int divs[4] = '{int'(frc_pkg::DIV_500K), int'(frc_pkg::DIV_300K),
                    int'(frc_pkg::DIV_250K), int'(frc_pkg::DIV_1M)};
    for (int c = 0; c < 4; c++) begin
      host.cfg_rate(2'(c));
      cyc(6);
      ticks(n);
      check(32'(n), 32'(24 / divs[c]));
    end
    $display("test clock scaling done");
  endtask

  task automatic t_perp();
    reg_wr(frc_pkg::CMD_ADDR, 32'h1);
    host.cfg_rate(frc_pkg::RATE_1M);
    cyc(3);
    check(32'(id_to_data_gap), 32'(frc_pkg::GAP_PERP_1M));
    reg_rd(frc_pkg::STATUS_ADDR);
    check(32'(rv[7]), 32'h1);
    write_req <= 1'b1;
    cyc(2);
    check(32'(write_gate), 32'h1);
    write_req <= 1'b0;
    host.cfg_rate(frc_pkg::RATE_500K);
    cyc(3);
    check(32'(id_to_data_gap), 32'(frc_pkg::GAP_STD));
    reg_wr(frc_pkg::CMD_ADDR, 32'h0);
    host.cfg_rate(frc_pkg::RATE_1M);
    cyc(3);
    check(32'(id_to_data_gap), 32'(frc_pkg::GAP_STD));
    write_req <= 1'b1;
    cyc(4);
    check(32'(write_gate), 32'h0);
    preamble_near <= 1'b1;
    cyc(2);
    check(32'(write_gate), 32'h1);
    write_req     <= 1'b0;
    preamble_near <= 1'b0;
    $display("test perpendicular done");
  endtask

  task automatic t_precomp();
    reg_wr(frc_pkg::RATE_SEL_ADDR, 32'h14); // precomp code 5
    reg_wr(frc_pkg::CMD_ADDR, 32'h2000); // start track 0x20
    reg_rd(frc_pkg::STATUS_ADDR);
    check(32'(rv[12:10]), 32'h5);
    check(32'(rv[20:13]), 32'h20);
    cur_track <= 8'h10;
    bits(1'b0);
    reg_wr(frc_pkg::RATE_SEL_ADDR, 32'h1c); // code 7 stops shifting
    cur_track <= 8'h30;
    bits(1'b0);
    reg_wr(frc_pkg::RATE_SEL_ADDR, 32'h14); // code 5 above start track
    bits(1'b1);
    reg_wr(frc_pkg::RATE_SEL_ADDR, 32'h0);
    reg_wr(frc_pkg::CMD_ADDR, 32'h0);
    $display("test precompensation done");
  endtask

  task automatic t_lowpwr();
    int n;
    reg_wr(frc_pkg::RATE_SEL_ADDR, 32'h40);
    cyc(2);
    check(32'(osc_enable), 32'h0);
    ticks(n);
    check(32'(n), 32'h0);
    reg_rd(frc_pkg::RATE_RB_ADDR);
    check(32'(rv[6]), 32'h1);
    wake_access <= 1'b1;
    @(posedge ref_clk);
    wake_access <= 1'b0;
    cyc(3);
    check(32'(osc_enable), 32'h1);
    reg_rd(frc_pkg::RATE_RB_ADDR);
    check(32'(rv[6]), 32'h0);
    reg_wr(frc_pkg::CMD_ADDR, 32'h2);
    cyc(2);
    check(32'(osc_enable), 32'h0);
    reg_wr(frc_pkg::CMD_ADDR, 32'h0);
    cyc(2);
    check(32'(osc_enable), 32'h1);
    n = sw_pulses;
    reg_wr(frc_pkg::RATE_SEL_ADDR, 32'h80); // self-clearing reset bit
    cyc(2);
    check(32'(sw_pulses - n), 32'h1);
    $display("test low power done");
  endtask

  task automatic t_refuse();
    host.wr(14'h0800, 32'h1, rr);
    check(32'(rr), 32'(frc_pkg::RESP_SLVERR));
    reg_rd(14'h0800);
    check(32'(rr), 32'(frc_pkg::RESP_SLVERR));
    host.wr(frc_pkg::STATUS_ADDR, 32'h1, rr);
    check(32'(rr), 32'(frc_pkg::RESP_SLVERR));
    reg_rd(frc_pkg::CFG_CTL_ADDR);
    check(rv, 32'h0);
    check(32'(rr), 32'(frc_pkg::RESP_OKAY));
    $display("test refused access done");
  endtask

  // main sequence
  initial begin
    cur_track       = 8'h00;
    write_bit       = 1'b0;
    write_bit_valid = 1'b0;
    preamble_near   = 1'b0;
    write_req       = 1'b0;
    wake_access     = 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_rate();
    t_scale();
    t_perp();
    t_precomp();
    t_lowpwr();
    t_refuse();
    finish_test();
  end

  // watchdog, far beyond the few hundred cycles the tests take
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule // frc_ctrl_tb
`default_nettype wire
